//--- fau_fp_add.sv
// Purpose: combinational ieee add of two values of one width
// Assumes: subnormal operands are not handled and report unimplemented
// Notes: tiny results flush to signed zero with underflow and inexact
`timescale 1ns/1ps
module fau_fp_add import fau_pkg::*; #(
  parameter int EW = 8,
  parameter int MW = 23
) (
  input wire logic [EW+MW:0] i_a,
  input wire logic [EW+MW:0] i_b,
  input wire logic [1:0] i_rm,
  output logic [EW+MW:0] o_y,
  output fau_cause_t o_cause
);
  localparam int W = EW + MW + 1;
  localparam int FW = MW + 4;
  localparam logic [EW-1:0] EMAX = '1;
  localparam logic [EW+1:0] EMAXS = {2'h0, EMAX};
  localparam logic [EW+MW:0] QNAN = {1'b0, EMAX, 1'b1, {(MW-1){1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // operand classes and magnitude ordering
  wire [EW-1:0] ea = i_a[W-2:MW];
  wire [EW-1:0] eb = i_b[W-2:MW];
  wire a_nan = (ea == EMAX) && |i_a[MW-1:0];
  wire b_nan = (eb == EMAX) && |i_b[MW-1:0];
  wire a_inf = (ea == EMAX) && ~|i_a[MW-1:0];
  wire b_inf = (eb == EMAX) && ~|i_b[MW-1:0];
  wire a_den = (ea == '0) && |i_a[MW-1:0];
  wire b_den = (eb == '0) && |i_b[MW-1:0];
  wire a_big = i_a[W-2:0] >= i_b[W-2:0];
  wire [W-1:0] x = a_big ? i_a : i_b;
  wire [W-1:0] y = a_big ? i_b : i_a;
  wire x_zero = ~|x[W-2:0];
  wire y_zero = ~|y[W-2:0];
  wire eff_sub = x[W-1] ^ y[W-1];
  wire [EW-1:0] dexp = x[W-2:MW] - y[W-2:MW];
  wire [FW-1:0] mx = {1'b1, x[MW-1:0], 3'h0};
  wire [FW-1:0] my0 = {1'b1, y[MW-1:0], 3'h0};
  wire [FW-1:0] one = {{(FW-1){1'b0}}, 1'b1};
  wire zsign = (x[W-1] & y[W-1]) | (eff_sub & (i_rm == FAU_RM_RM));
  wire ovf_inf = (i_rm == FAU_RM_RN) | ((i_rm == FAU_RM_RP) & ~x[W-1])
                 | ((i_rm == FAU_RM_RM) & x[W-1]);

  logic [FW-1:0] my;
  logic [FW:0] sum;
  logic [FW-1:0] nrm;
  logic [EW+1:0] en;
  logic [MW+1:0] rnd;
  logic inc;

  ////////////////////////////////////////////////////////////////////////////
  // align, add at full width, normalise, round by mode, then classify
  always_comb begin
    if (dexp >= EW'(FW)) begin
      my = one;
    end else begin
      my = (my0 >> dexp) | (|(my0 & ~({FW{1'b1}} << dexp)) ? one : '0);
    end
    sum = eff_sub ? {1'b0, mx} - {1'b0, my} : {1'b0, mx} + {1'b0, my};
    nrm = sum[FW-1:0];
    en = {2'h0, x[W-2:MW]};
    if (sum[FW]) begin
      nrm = {sum[FW:2], sum[1] | sum[0]};
      en = en + 1'b1;
    end else begin
      for (int k = 0; k < FW; k++) begin
        if (!nrm[FW-1]) begin
          nrm = nrm << 1;
          en = en - 1'b1;
        end
      end
    end
    case (i_rm)
      FAU_RM_RN: inc = nrm[2] & (nrm[3] | nrm[1] | nrm[0]);
      FAU_RM_RP: inc = ~x[W-1] & |nrm[2:0];
      FAU_RM_RM: inc = x[W-1] & |nrm[2:0];
      default: inc = 1'b0;
    endcase
    rnd = {1'b0, nrm[FW-1:3]} + {{(MW+1){1'b0}}, inc};
    if (rnd[MW+1]) begin
      en = en + 1'b1;
    end
    o_cause = '0;
    o_y = {x[W-1], en[EW-1:0], rnd[MW-1:0]};
    if (a_den | b_den) begin
      o_cause.e = 1'b1;
      o_y = QNAN;
    end else if (a_nan | b_nan | (a_inf & b_inf & eff_sub)) begin
      o_cause.v = 1'b1;
      o_y = QNAN;
    end else if (a_inf | b_inf) begin
      o_y = x;
    end else if (x_zero || sum == '0) begin
      o_y = {zsign, {(W-1){1'b0}}};
    end else if (y_zero) begin
      o_y = x;
    end else if (!en[EW+1] && en >= EMAXS) begin
      o_cause.o = 1'b1;
      o_cause.i = 1'b1;
      o_y = ovf_inf ? {x[W-1], EMAX, {MW{1'b0}}} : {x[W-1], EMAX - 1'b1, {MW{1'b1}}};
    end else if (en[EW+1] || en == '0) begin
      o_cause.u = 1'b1;
      o_cause.i = 1'b1;
      o_y = {x[W-1], {(W-1){1'b0}}};
    end else begin
      o_cause.i = |nrm[2:0];
    end
  end
endmodule : fau_fp_add

//--- fau_pipe_model.sv
// Purpose: pipeline-side model that issues decoded fp instructions
// Assumes: one instruction per high cycle of o_issue_valid, no ready
// Notes: fields are inverted after each burst so stale values never pass
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fau_pipe_model import fau_pkg::*; (
  input wire logic i_mclk,
  output logic o_issue_valid,
  output fau_instr_t o_instr,
  output logic o_cop_usable
);
  // nothing is issued before the first call
  initial begin
    o_issue_valid = 1'h0;
    o_instr = '0;
    o_cop_usable = 1'h1;
  end
  // one instruction per call; h keeps valid up for a back-to-back issue
  // fields come from the caller, valid for the format; no sixteen-register mode here
  task issue(input logic [5:0] fn, input logic [4:0] fmt, ft, fs, fd,
             input logic u, h);
    o_issue_valid <= 1'h1;
    o_instr <= {FAU_OPC_COP, fmt, ft, fs, fd, fn};
    o_cop_usable <= u;
    @(posedge i_mclk);
    if (!h) begin
      o_issue_valid <= 1'h0;
      o_instr <= ~o_instr; // idle fields hold no meaning
      @(posedge i_mclk);
    end
  endtask : issue
  // one raw word with the unit usable, for encodings outside the decoded set
  task issue_word(input fau_instr_t w);
    o_issue_valid <= 1'h1;
    o_instr <= w;
    o_cop_usable <= 1'h1;
    @(posedge i_mclk);
    o_issue_valid <= 1'h0;
    o_instr <= ~w;
    @(posedge i_mclk);
  endtask : issue_word
endmodule : fau_pipe_model

//--- fau_pkg.sv
// Purpose: shared constants and types for the fp absolute value / add unit
// Assumes: one clock, synchronous active-high reset
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package fau_pkg;
  // instruction encodings
  localparam logic [5:0] FAU_OPC_COP = 6'h11;
  localparam logic [4:0] FAU_FMT_S = 5'h10;
  localparam logic [4:0] FAU_FMT_D = 5'h11;
  localparam logic [4:0] FAU_FMT_PS = 5'h16;
  localparam logic [5:0] FAU_FN_ADD = 6'h00;
  localparam logic [5:0] FAU_FN_ABS = 6'h05;
  // rounding modes
  localparam logic [1:0] FAU_RM_RN = 2'h0;
  localparam logic [1:0] FAU_RM_RZ = 2'h1;
  localparam logic [1:0] FAU_RM_RP = 2'h2;
  localparam logic [1:0] FAU_RM_RM = 2'h3;
  // float widths
  localparam int FAU_SEW = 8;
  localparam int FAU_SMW = 23;
  localparam int FAU_DEW = 11;
  localparam int FAU_DMW = 52;
  localparam int FAU_NREG = 32;
  localparam int FAU_NFLG = 5;
  localparam int FAU_NBYTE = 4;
  localparam int FAU_BYTE = 8;
  // register map
  localparam logic [7:0] FAU_A_FP_CONTROL_STATUS_REG = 8'h00;
  localparam logic [7:0] FAU_A_ISTAT = 8'h04;
  localparam logic [7:0] FAU_A_IMASK = 8'h08;
  localparam logic [7:0] FAU_A_FSEL = 8'h0c;
  localparam logic [7:0] FAU_A_FLO = 8'h10;
  localparam logic [7:0] FAU_A_FHI = 8'h14;
  localparam logic [1:0] FAU_OKAY = 2'h0;
  localparam logic [1:0] FAU_SLVERR = 2'h2;
  // interrupt event bits
  localparam int FAU_NEV = 3;
  localparam int FAU_EV_DONE = 0;
  localparam int FAU_EV_TRAP = 1;
  localparam int FAU_EV_IEXC = 2;

  typedef struct packed {
    logic [5:0] opc;
    logic [4:0] fmt;
    logic [4:0] ft;
    logic [4:0] fs;
    logic [4:0] fd;
    logic [5:0] func;
  } fau_instr_t;
  typedef struct packed {logic e; logic v; logic z; logic o; logic u; logic i;} fau_cause_t;
  typedef struct packed {
    logic [13:0] rsvd;
    fau_cause_t cause;
    logic [4:0] ena;
    logic [4:0] flg;
    logic [1:0] rm;
  } fau_fp_control_status_reg_t;
  typedef struct packed {logic sign; logic [7:0] exp; logic [22:0] man;} fau_sgl_t;
  typedef struct packed {logic sign; logic [10:0] exp; logic [51:0] man;} fau_dbl_t;
  typedef struct packed {fau_sgl_t hi; fau_sgl_t lo;} fau_pair_t;
  typedef enum logic [1:0] {FAU_WS_IDLE = 2'b01, FAU_WS_RESP = 2'b10} fau_wst_t;
endpackage : fau_pkg

//--- fau_top.sv
// Purpose: fp absolute value and add unit with register file and control/status
// Assumes: one instruction may issue per clock; result lands one clock later
// Notes: register file and control/status also reachable over AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - absolute value writes the magnitude of the source into the destination in the format.
// - paired-single absolute value treats each half alone and ORs their conditions.
// - with no exception taken, the produced cause bits are ORed into the sticky flags.
// - absolute value is arithmetic, so a NaN operand raises invalid operation.
// - absolute value raises coprocessor unusable, reserved instruction, and fp trap on unimplemented or enabled invalid.
// - absolute value reports only unimplemented operation and invalid operation.
// - add sums the sources exactly, rounds by the current mode and writes the destination.
// - paired-single add sums each half alone and ORs their conditions.
// - add may report unimplemented, invalid, inexact, overflow and underflow.
module fau_top import fau_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_issue_valid,
  input wire fau_instr_t i_instr,
  input wire logic i_cop_usable,
  output logic o_done,
  output logic o_fp_trap,
  output logic o_cop_unusable,
  output logic o_reserved_instr,
  output logic o_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  logic [63:0] fp_register [FAU_NREG];
  fau_fp_control_status_reg_t fp_control_status_reg, next_fp_control_status_reg;
  logic [FAU_NEV-1:0] istat, imask, next_istat, next_imask;
  logic [4:0] fsel;
  logic [31:0] lo_stage;
  fau_wst_t wst, next_wst;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < FAU_NBYTE; b++) begin
      if (st[b]) r[b*FAU_BYTE +: FAU_BYTE] = nw[b*FAU_BYTE +: FAU_BYTE];
    end
    return r;
  endfunction : merge

  function automatic fau_cause_t abs_cause(input logic e_ones, input logic e_zero,
                                           input logic m_nz);
    fau_cause_t c;
    c = '0;
    c.v = e_ones & m_nz;
    c.e = e_zero & m_nz;
    return c;
  endfunction : abs_cause

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode and exception class
  wire fmt_s = i_instr.fmt == FAU_FMT_S;
  wire fmt_d = i_instr.fmt == FAU_FMT_D;
  wire fmt_ps = i_instr.fmt == FAU_FMT_PS;
  wire op_add = i_instr.func == FAU_FN_ADD;
  wire op_abs = (i_instr.func == FAU_FN_ABS) && (i_instr.ft == '0);
  wire legal = (i_instr.opc == FAU_OPC_COP) && (fmt_s | fmt_d | fmt_ps) && (op_add | op_abs);
  wire cu_exc = i_issue_valid && !i_cop_usable;
  wire ri_exc = i_issue_valid && i_cop_usable && !legal;
  wire ex_go = i_issue_valid && i_cop_usable && legal;
  wire [63:0] vs = fp_register[i_instr.fs];
  wire [63:0] vt = fp_register[i_instr.ft];
  wire fau_pair_t vs_p = fau_pair_t'(vs);
  wire fau_dbl_t vs_d = fau_dbl_t'(vs);
  wire fau_pair_t vt_p = fau_pair_t'(vt);

  ////////////////////////////////////////////////////////////////////////////
  // adders: one double, two singles for the halves
  logic [63:0] d_sum;
  logic [31:0] hi_sum, lo_sum;
  fau_cause_t d_c, hi_c, lo_c;
  fau_fp_add #(.EW(FAU_DEW), .MW(FAU_DMW)) u_add_d (
    .i_a(vs), .i_b(vt), .i_rm(fp_control_status_reg.rm), .o_y(d_sum), .o_cause(d_c));
  fau_fp_add #(.EW(FAU_SEW), .MW(FAU_SMW)) u_add_hi (
    .i_a(vs_p.hi), .i_b(vt_p.hi), .i_rm(fp_control_status_reg.rm), .o_y(hi_sum), .o_cause(hi_c));
  fau_fp_add #(.EW(FAU_SEW), .MW(FAU_SMW)) u_add_lo (
    .i_a(vs_p.lo), .i_b(vt_p.lo), .i_rm(fp_control_status_reg.rm), .o_y(lo_sum), .o_cause(lo_c));

  ////////////////////////////////////////////////////////////////////////////
  // absolute value: clear sign, flag NaN as invalid and subnormal as unimplemented
  fau_pair_t abs_p;
  fau_dbl_t abs_d;
  always_comb begin
    abs_p = vs_p;
    abs_p.hi.sign = 1'b0;
    abs_p.lo.sign = 1'b0;
    abs_d = vs_d;
    abs_d.sign = 1'b0;
  end
  wire fau_cause_t habs_c = abs_cause(&vs_p.hi.exp, ~|vs_p.hi.exp, |vs_p.hi.man);
  wire fau_cause_t labs_c = abs_cause(&vs_p.lo.exp, ~|vs_p.lo.exp, |vs_p.lo.man);
  wire fau_cause_t dabs_c = abs_cause(&vs_d.exp, ~|vs_d.exp, |vs_d.man);

  // result and cause selection by operation and format
  wire fau_cause_t abs_c = fmt_d ? dabs_c : (fmt_ps ? fau_cause_t'(habs_c | labs_c) : labs_c);
  wire fau_cause_t add_c = fmt_d ? d_c : (fmt_ps ? fau_cause_t'(hi_c | lo_c) : lo_c);
  wire fau_cause_t cause = op_abs ? abs_c : add_c;
  wire [63:0] abs_r = fmt_d ? abs_d : (fmt_ps ? abs_p : {vs_p.hi, abs_p.lo});
  wire [63:0] add_r = fmt_d ? d_sum : (fmt_ps ? {hi_sum, lo_sum} : {vs_p.hi, lo_sum});
  wire [63:0] res = op_abs ? abs_r : add_r;
  wire trap = cause.e | |(cause[FAU_NFLG-1:0] & fp_control_status_reg.ena);
  wire commit = ex_go && !trap;

  ////////////////////////////////////////////////////////////////////////////
  // bus write decode
  wire axi_we = (wst == FAU_WS_IDLE) && i_awvalid && i_wvalid;
  wire we_fp_control_status_reg = axi_we && (i_awaddr == FAU_A_FP_CONTROL_STATUS_REG);
  wire we_istat = axi_we && (i_awaddr == FAU_A_ISTAT);
  wire we_imask = axi_we && (i_awaddr == FAU_A_IMASK);
  wire we_fsel = axi_we && (i_awaddr == FAU_A_FSEL);
  wire we_flo = axi_we && (i_awaddr == FAU_A_FLO);
  wire we_fhi = axi_we && (i_awaddr == FAU_A_FHI);
  wire w_hit = we_fp_control_status_reg | we_istat | we_imask | we_fsel | we_flo | we_fhi;
  wire [63:0] sel_v = fp_register[fsel];
  wire [FAU_NEV-1:0] ev_clr = we_istat ? i_wdata[FAU_NEV-1:0] : '0;
  wire [FAU_NEV-1:0] ev_set = {cu_exc | ri_exc, ex_go & trap, commit};

  // control/status: bus write first, then this op's cause and sticky flags
  always_comb begin
    next_fp_control_status_reg = we_fp_control_status_reg ? fau_fp_control_status_reg_t'(merge(fp_control_status_reg, i_wdata, i_wstrb)) : fp_control_status_reg;
    next_fp_control_status_reg.rsvd = '0;
    if (ex_go) begin
      next_fp_control_status_reg.cause = cause;
    end
    if (commit) begin
      next_fp_control_status_reg.flg = next_fp_control_status_reg.flg | cause[FAU_NFLG-1:0];
    end
  end
  assign next_istat = (istat & ~ev_clr) | ev_set;
  // merged bus words, sliced below since a call result cannot be indexed
  wire [31:0] imask_wr = merge({{(32-FAU_NEV){1'b0}}, imask}, i_wdata, i_wstrb);
  wire [31:0] fsel_wr = merge({27'h0, fsel}, i_wdata, i_wstrb);
  assign next_imask = we_imask ? imask_wr[FAU_NEV-1:0] : imask;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fp_control_status_reg <= '0;
      istat <= '0;
      imask <= '0;
      fsel <= '0;
      lo_stage <= '0;
      o_irq <= 1'b0;
    end else begin
      fp_control_status_reg <= next_fp_control_status_reg;
      istat <= next_istat;
      imask <= next_imask;
      fsel <= we_fsel ? fsel_wr[4:0] : fsel;
      lo_stage <= we_flo ? merge(lo_stage, i_wdata, i_wstrb) : lo_stage;
      o_irq <= |(next_istat & next_imask);
    end
  end

  // register file: bus high-word write, then the op result (op wins)
  always_ff @(posedge i_mclk) begin
    if (we_fhi) fp_register[fsel] <= {merge(sel_v[63:32], i_wdata, i_wstrb), lo_stage};
    if (commit) fp_register[i_instr.fd] <= res;
  end

  // issue answer pulses
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_fp_trap <= 1'b0;
      o_cop_unusable <= 1'b0;
      o_reserved_instr <= 1'b0;
    end else begin
      o_done <= commit;
      o_fp_trap <= ex_go && trap;
      o_cop_unusable <= cu_exc;
      o_reserved_instr <= ri_exc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always_comb begin
    case (wst)
      FAU_WS_IDLE: next_wst = (i_awvalid && i_wvalid) ? FAU_WS_RESP : FAU_WS_IDLE;
      FAU_WS_RESP: next_wst = i_bready ? FAU_WS_IDLE : FAU_WS_RESP;
      default: next_wst = FAU_WS_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wst <= FAU_WS_IDLE;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= FAU_OKAY;
    end else begin
      wst <= next_wst;
      o_awready <= next_wst == FAU_WS_IDLE;
      o_wready <= next_wst == FAU_WS_IDLE;
      o_bvalid <= next_wst == FAU_WS_RESP;
      if (axi_we) o_bresp <= w_hit ? FAU_OKAY : FAU_SLVERR;
    end
  end

  // AXI4-Lite read channel
  wire r_fp_control_status_reg = i_araddr == FAU_A_FP_CONTROL_STATUS_REG;
  wire r_istat = i_araddr == FAU_A_ISTAT;
  wire r_imask = i_araddr == FAU_A_IMASK;
  wire r_fsel = i_araddr == FAU_A_FSEL;
  wire r_flo = i_araddr == FAU_A_FLO;
  wire r_fhi = i_araddr == FAU_A_FHI;
  wire r_hit = r_fp_control_status_reg | r_istat | r_imask | r_fsel | r_flo | r_fhi;
  wire [31:0] rd_mux = r_fp_control_status_reg ? fp_control_status_reg : r_istat ? {{(32-FAU_NEV){1'b0}}, istat}
                     : r_imask ? {{(32-FAU_NEV){1'b0}}, imask} : r_fsel ? {27'h0, fsel}
                     : r_flo ? sel_v[31:0] : r_fhi ? sel_v[63:32] : 32'h0;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= FAU_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= r_hit ? FAU_OKAY : FAU_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_abs_sign_clear: assert property ((ex_go && op_abs && fmt_d && !trap && !we_fhi)
    |=> fp_register[$past(i_instr.fd)] == {1'b0, $past(vs[62:0])})
    else $error("abs double did not clear sign");
  a_ps_abs_halves: assert property ((ex_go && op_abs && fmt_ps && !trap && !we_fhi)
    |=> !fp_register[$past(i_instr.fd)][63] && !fp_register[$past(i_instr.fd)][31])
    else $error("paired abs left a sign set");
  a_flags_sticky: assert property ((commit && !we_fp_control_status_reg)
    |=> fp_control_status_reg.flg == ($past(fp_control_status_reg.flg) | $past(cause[FAU_NFLG-1:0])))
    else $error("flags not ored from cause");
  a_trap_no_flag: assert property ((ex_go && trap && !we_fp_control_status_reg)
    |=> fp_control_status_reg.flg == $past(fp_control_status_reg.flg) && o_fp_trap && !o_done)
    else $error("trap changed flags or missed pulse");
  a_abs_nan_inv: assert property ((ex_go && op_abs && fmt_d && &vs_d.exp && |vs_d.man)
    |-> cause.v ##1 o_fp_trap || fp_control_status_reg.cause.v)
    else $error("nan abs not invalid");
  a_abs_causes: assert property ((ex_go && op_abs)
    |-> !cause.o && !cause.u && !cause.i && !cause.z)
    else $error("abs raised a forbidden cause");
  a_cop_unusable: assert property (cu_exc
    |=> o_cop_unusable && !o_done && !o_fp_trap ##1 (!o_cop_unusable || $past(cu_exc)))
    else $error("coprocessor unusable not reported");
  a_rz_no_inf: assert property ((ex_go && op_add && fmt_s && fp_control_status_reg.rm == FAU_RM_RZ && lo_c.o)
    |-> lo_sum[30:0] == {8'hfe, 23'h7fffff})
    else $error("round to zero overflowed to infinity");
  a_ps_add_or: assert property ((ex_go && op_add && fmt_ps)
    |-> cause == (hi_c | lo_c))
    else $error("paired add causes not combined");
  a_add_causes: assert property ((ex_go && op_add) |-> !cause.z)
    else $error("add raised divide by zero");
  a_bad_opcode: assert property ((i_issue_valid && i_cop_usable && i_instr.opc != FAU_OPC_COP)
    |=> o_reserved_instr && !o_done)
    else $error("bad opcode not reserved");
  c_ps_abs: cover property (commit && op_abs && fmt_ps);
  c_add_trap: cover property (ex_go && op_add && trap);
  c_irq: cover property (!o_irq ##1 o_irq);
  c_axi_wr: cover property (axi_we ##[1:4] (o_bvalid && i_bready));
endmodule : fau_top

//--- test_fp_abs_add_unit.sv
// Purpose: self-checking bench for the fp absolute value and add unit
// Assumes: bus master lives here, instructions come from fau_pipe_model
// Notes: drivers queue expectations, one monitor compares them
`timescale 1ns/1ps
module test_fp_abs_add_unit import fau_pkg::*; ;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, done, trap, cu, ri, irq, iv, usable;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  fau_instr_t instr;
  logic [63:0] rq[$], bq[$], iq[$];
  logic [63:0] v;
  int miscompares = 0;
  int compares = 0;
  int seed = 32'hb897e606;
  always #5 mclk = ~mclk;
  fau_pipe_model i_fau_pipe_model (.i_mclk(mclk), .o_issue_valid(iv), .o_instr(instr),
    .o_cop_usable(usable));
  fau_top i_fau_top (.i_mclk(mclk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_issue_valid(iv),
    .i_instr(instr), .i_cop_usable(usable), .o_done(done), .o_fp_trap(trap),
    .o_cop_unusable(cu), .o_reserved_instr(ri), .o_irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task chk(input logic [63:0] g, e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wt(input int n);
    if (n >= 50) begin
      miscompares++;
      end_of_test();
    end
  endtask : wt
  // bus write: address and data together, response awaited under a bound
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    bq.push_back({62'h0, e});
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin @(posedge mclk); n++; end while (!(awready && wready) && n < 50);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do begin @(posedge mclk); n++; end while (!bvalid && n < 50);
    bready <= 1'h0;
    wt(n);
  endtask : axw
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    rq.push_back({30'h0, e, d});
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin @(posedge mclk); n++; end while (!arready && n < 50);
    arvalid <= 1'h0;
    do begin @(posedge mclk); n++; end while (!rvalid && n < 50);
    rready <= 1'h0;
    wt(n);
  endtask : axr
  task wrf(input logic [4:0] i, input logic [63:0] d);
    axw(FAU_A_FSEL, {27'h0, i}, FAU_OKAY);
    axw(FAU_A_FLO, d[31:0], FAU_OKAY);
    axw(FAU_A_FHI, d[63:32], FAU_OKAY);
  endtask : wrf
  task rdf(input logic [4:0] i, input logic [63:0] d);
    axw(FAU_A_FSEL, {27'h0, i}, FAU_OKAY);
    axr(FAU_A_FLO, d[31:0], FAU_OKAY);
    axr(FAU_A_FHI, d[63:32], FAU_OKAY);
  endtask : rdf
  // e is the expected pulse set {done, trap, cop unusable, reserved}
  task op(input logic [5:0] fn, input logic [4:0] fmt, ft, fs, fd, input logic u, h,
          input logic [3:0] e);
    iq.push_back({60'h0, e});
    i_fau_pipe_model.issue(fn, fmt, ft, fs, fd, u, h);
  endtask : op
  //////////////////////////////////////////////////////////////////////////////
  // monitor: each answer takes the oldest expectation of its channel
  always @(posedge mclk) begin
    if (rvalid && rready)
      chk({30'h0, rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
    if (bvalid && bready)
      chk({62'h0, bresp}, bq.size() ? bq.pop_front() : 'x);
    if (done || trap || cu || ri)
      chk({60'h0, done, trap, cu, ri}, iq.size() ? iq.pop_front() : 'x);
  end
  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h0, FAU_OKAY);
    axr(FAU_A_IMASK, 32'h0, FAU_OKAY);
    axw(8'h18, 32'h1, FAU_SLVERR);
    axr(8'h1c, 32'h0, FAU_SLVERR);
    axw(FAU_A_FP_CONTROL_STATUS_REG, 32'hffffffff, FAU_OKAY);
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h0003ffff, FAU_OKAY);
    axw(FAU_A_FP_CONTROL_STATUS_REG, 32'h0, FAU_OKAY);
    // abs then add back to back, the add reads the abs result
    wrf(5'h1, 64'h12345678_bfc00000);
    op(FAU_FN_ABS, FAU_FMT_S, 5'h0, 5'h1, 5'h2, 1'h1, 1'h1, 4'h8);
    op(FAU_FN_ADD, FAU_FMT_S, 5'h2, 5'h2, 5'h4, 1'h1, 1'h0, 4'h8);
    rdf(5'h2, 64'h12345678_3fc00000);
    rdf(5'h4, 64'h12345678_40400000);
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h0, FAU_OKAY);
    // paired abs: negative upper half, nan lower half
    wrf(5'h3, 64'hc0000000_ffc00000);
    op(FAU_FN_ABS, FAU_FMT_PS, 5'h0, 5'h3, 5'h7, 1'h1, 1'h0, 4'h8);
    rdf(5'h7, 64'h40000000_7fc00000);
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h00010040, FAU_OKAY);
    // halfway sum in every rounding mode
    wrf(5'h8, 64'h3f800000);
    wrf(5'h9, 64'h33800000);
    for (int m = 0; m < 4; m++) begin
      axw(FAU_A_FP_CONTROL_STATUS_REG, 32'(m), FAU_OKAY);
      op(FAU_FN_ADD, FAU_FMT_S, 5'h9, 5'h8, 5'ha, 1'h1, 1'h0, 4'h8);
      rdf(5'ha, {32'h0, 32'h3f800000 + 32'(m == 2)});
      axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h1004 + 32'(m), FAU_OKAY);
    end
    wrf(5'hb, 64'h3ff00000_00000000);
    op(FAU_FN_ADD, FAU_FMT_D, 5'hb, 5'hb, 5'hc, 1'h1, 1'h0, 4'h8);
    rdf(5'hc, 64'h40000000_00000000);
    // double abs clears the sign of the whole word
    wrf(5'h12, 64'hc0100000_00000000);
    op(FAU_FN_ABS, FAU_FMT_D, 5'h0, 5'h12, 5'h13, 1'h1, 1'h0, 4'h8);
    rdf(5'h13, 64'h40100000_00000000);
    // paired add, lower half overflows
    axw(FAU_A_FP_CONTROL_STATUS_REG, 32'h0, FAU_OKAY);
    wrf(5'hd, 64'h3f800000_7f7fffff);
    wrf(5'he, 64'h40000000_7f7fffff);
    op(FAU_FN_ADD, FAU_FMT_PS, 5'he, 5'hd, 5'hf, 1'h1, 1'h0, 4'h8);
    rdf(5'hf, 64'h40400000_7f800000);
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h00005014, FAU_OKAY);
    // single overflow toward zero gives the largest finite value
    axw(FAU_A_FP_CONTROL_STATUS_REG, {30'h0, FAU_RM_RZ}, FAU_OKAY);
    op(FAU_FN_ADD, FAU_FMT_S, 5'he, 5'hd, 5'h14, 1'h1, 1'h0, 4'h8);
    rdf(5'h14, 64'h3f800000_7f7fffff);
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h00005015, FAU_OKAY);
    // enabled invalid traps: destination and flags kept; then a subnormal traps as unimplemented, flags kept
    axw(FAU_A_FP_CONTROL_STATUS_REG, 32'h800, FAU_OKAY);
    op(FAU_FN_ABS, FAU_FMT_S, 5'h0, 5'h3, 5'h7, 1'h1, 1'h0, 4'h4);
    rdf(5'h7, 64'h40000000_7fc00000);
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h00010800, FAU_OKAY);
    wrf(5'h10, 64'h1);
    op(FAU_FN_ABS, FAU_FMT_S, 5'h0, 5'h10, 5'h11, 1'h1, 1'h0, 4'h4);
    axr(FAU_A_FP_CONTROL_STATUS_REG, 32'h00020800, FAU_OKAY);
    // instruction-level exceptions
    op(FAU_FN_ADD, FAU_FMT_S, 5'h1, 5'h1, 5'h1, 1'h0, 1'h0, 4'h2);
    op(FAU_FN_ABS, FAU_FMT_S, 5'h1, 5'h1, 5'h1, 1'h1, 1'h0, 4'h1);
    iq.push_back(64'h1);
    i_fau_pipe_model.issue_word({6'h12, FAU_FMT_S, 15'h0, FAU_FN_ADD});
    // sticky events, mask and write-one-to-clear
    axr(FAU_A_ISTAT, 32'h7, FAU_OKAY);
    axw(FAU_A_IMASK, 32'h2, FAU_OKAY);
    repeat (2) @(posedge mclk);
    chk({63'h0, irq}, 64'h1);
    axw(FAU_A_ISTAT, 32'h2, FAU_OKAY);
    repeat (2) @(posedge mclk);
    chk({63'h0, irq}, 64'h0);
    axr(FAU_A_ISTAT, 32'h5, FAU_OKAY);
    // random normal values through single abs
    for (int k = 0; k < 8; k++) begin
      v = {$random(seed), $random(seed)};
      v[30] = ~v[29];
      wrf(5'h5, v);
      op(FAU_FN_ABS, FAU_FMT_S, 5'h0, 5'h5, 5'h6, 1'h1, 1'h0, 4'h8);
      rdf(5'h6, {v[63:32], 1'h0, v[30:0]});
    end
    repeat (4) @(posedge mclk);
    if (rq.size() + bq.size() + iq.size() != 0)
      miscompares++;
    end_of_test();
  end
endmodule : test_fp_abs_add_unit
